// *** include/srm_pkg.sv ***
// Shared constants and types of the standby RAM module.
package srm_pkg;
    // Register indices on the plain register port (16-bit registers).
    localparam logic [2:0] CFG_IDX = 3'h0;
    localparam logic [2:0] TEST_IDX = 3'h1;
    localparam logic [2:0] BASE_HIGH_IDX = 3'h2;
    localparam logic [2:0] BASE_LOW_IDX = 3'h3;
    localparam logic [2:0] STATUS_IDX = 3'h4;
    localparam logic [2:0] MASK_IDX = 3'h5;

    // Field positions in ram_module_config_reg.
    localparam int STOP_BIT = 15;
    localparam int LOCK_BIT = 11;
    localparam int SPACE_LSB = 8;
    localparam int PDS_BIT = 7;

    // Event bit positions in the status and mask registers.
    localparam int EV_POWER_LOSS = 0;
    localparam int EV_STANDBY_REFUSE = 1;
    localparam int EV_LOCKED_WRITE = 2;
    localparam int EV_COUNT = 3;

    // Values after reset.
    localparam logic RST_STOP = 1'b1;
    localparam logic RST_LOCK = 1'b0;
    localparam logic [1:0] RST_SPACE = 2'h1;
    localparam logic RST_PDS = 1'b0;
    localparam logic [7:0] RST_BASE_HIGH = 8'h00;
    localparam logic [15:0] RST_BASE_LOW = 16'h0000;

    // Access sizes on the array port.
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_WORD = 2'h1;
    localparam logic [1:0] SIZE_LONG = 2'h2;

    // Bus cycle length in system clocks.
    localparam int BUS_CYCLE_CLKS = 2;

    // Base addresses in this range can never be reached.
    localparam logic [23:0] DEAD_LOW = 24'h080000;
    localparam logic [23:0] DEAD_HIGH = 24'hF7FFFF;

    // Two clocks per bus cycle, up to two bus cycles per access.
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_C1A = 3'h1,
        ST_C1B = 3'h3,
        ST_C2A = 3'h2,
        ST_C2B = 3'h6
    } srm_state_e;
endpackage

// *** rtl/srm_top.sv ***
// Standby RAM module: control registers, relocatable array and access sequencer.
//
// Functional notes
// RULE_01 - Array of 2 or 4 Kbytes, base aligned to its size, hits decoded from base.
// RULE_02 - Software picks a base that overlaps no other array or register block.
// RULE_03 - Array accepts byte, word and long-word reads and writes.
// RULE_04 - Unimplemented control bits read zero and ignore writes.
// RULE_05 - Base registers are written only while stopped and unlocked.
// RULE_06 - Base lock is set once by a write; later writes ignored until reset.
// RULE_07 - Base bits 23:20 must match bit 19; dead-range base leaves array unreachable.
// RULE_08 - Space-select low bit: 0 program and data, 1 program only.
// RULE_09 - Space-select high bit set makes user-mode accesses ignored.
// RULE_10 - Power-down status stays set while standby holds; cleared on loss.
// RULE_11 - Software may write power-down status to zero to stop monitoring.
// RULE_12 - Byte or aligned word takes one two-clock bus cycle; long or misaligned two.
// RULE_13 - Array accesses refused while running from the standby supply.
// RULE_14 - Reset sets stop, program-only space, clears bases and lock.
// RULE_15 - Synchronous reset during byte or word access lets the access complete.
// RULE_16 - Reset in first long word finishes that word; in second, finishes both.
// RULE_17 - While stopped the array does not answer; registers stay reachable.
`timescale 1ns/100ps
`default_nettype none
module srm_top
    import srm_pkg::*;
#(
    parameter int ARRAY_KB = 2
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic syncReset,
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdData,
    input wire logic arrReq,
    input wire logic [23:0] arrAddr,
    input wire logic arrWrite,
    input wire logic [1:0] arrSize,
    input wire logic arrProgram,
    input wire logic arrSuper,
    input wire logic [31:0] arrWrData,
    output logic [31:0] arrRdData,
    output logic arrAck,
    input wire logic onStandbySupply,
    input wire logic standbyVoltageLow,
    output logic irq
);
    localparam int AW = (ARRAY_KB == 4) ? 12 : 11;
    localparam int WORDS = (1 << AW) / 2;
    localparam logic [15:0] LOW_MASK = 16'(32'hFFFF << AW);

    typedef struct packed {
        srm_state_e st;
        logic [23:0] addr;
        logic [1:0] size;
        logic wr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic pendRst;
        logic stop;
        logic lock;
        logic [1:0] space;
        logic power_down_status_bit;
        logic [7:0] baseHigh;
        logic [15:0] baseLow;
        logic [EV_COUNT-1:0] status;
        logic [EV_COUNT-1:0] mask;
        logic [15:0] rd;
        logic ack;
        logic irq;
    } srm_state_s;

    srm_state_s state_reg;
    srm_state_s state_next;

    logic [15:0] mem [WORDS];

    logic [23:0] base;
    logic hit;
    logic reachable;
    logic twoPart;
    logic secondHalf;
    logic opNow;
    logic byteOp;
    logic [23:0] ea;
    logic [AW-2:0] memIdx;
    logic [15:0] memRdWord;
    logic [15:0] wsel;
    logic [15:0] memWdata;
    logic memWeHi;
    logic memWeLo;
    logic [7:0] rdByte;
    logic [EV_COUNT-1:0] events;
    logic [EV_COUNT-1:0] clearMask;
    logic resetNow;
    logic spaceOk;
    logic modeOk;
    logic takeOk;
    logic baseOpen;
    logic abortNow;

    always_comb begin
        base = {state_reg.baseHigh, state_reg.baseLow & LOW_MASK};
        // Only the bits above the array size take part in the match.
        hit = (arrAddr[23:AW] == base[23:AW]); // see RULE_01
        // A base in the dead range, or with bits 23:20 unlike bit 19, is unreachable.
        reachable = !((base >= DEAD_LOW) && (base <= DEAD_HIGH)); // see RULE_07
        spaceOk = arrProgram || !state_reg.space[0]; // see RULE_08
        modeOk = arrSuper || !state_reg.space[1]; // see RULE_09
        // Registers stay reachable while stopped; only the array goes quiet.
        takeOk = arrReq && hit && reachable && !state_reg.stop && // see RULE_17
            spaceOk && modeOk;
        baseOpen = state_reg.stop && !state_reg.lock; // see RULE_05
        twoPart = (state_reg.size == SIZE_LONG) ||
            ((state_reg.size == SIZE_WORD) && state_reg.addr[0]); // see RULE_12
        secondHalf = (state_reg.st == ST_C2B);
        opNow = (state_reg.st == ST_C1B) || (state_reg.st == ST_C2B);
        // A switch to the standby supply mid-access drops it before the current bus cycle writes the array.
        abortNow = opNow && onStandbySupply; // see RULE_13
        byteOp = (state_reg.size == SIZE_BYTE) ||
            ((state_reg.size == SIZE_WORD) && state_reg.addr[0]);
        // Effective byte address of the current bus cycle.
        if (state_reg.size == SIZE_LONG) begin
            ea = {state_reg.addr[23:1], 1'b0} + (secondHalf ? 24'h000002 : 24'h000000);
        end else begin
            ea = state_reg.addr + (secondHalf ? 24'h000001 : 24'h000000);
        end
        memIdx = ea[AW-1:1];
        memRdWord = mem[memIdx];
        // Long words move high half first, as the bus is big-endian.
        if (state_reg.size == SIZE_LONG) begin
            wsel = secondHalf ? state_reg.wdata[15:0] : state_reg.wdata[31:16];
        end else if (byteOp && twoPart && !secondHalf) begin
            wsel = {8'h00, state_reg.wdata[15:8]};
        end else begin
            wsel = state_reg.wdata[15:0];
        end
        memWdata = byteOp ? {wsel[7:0], wsel[7:0]} : wsel;
        memWeHi = opNow && state_reg.wr && !abortNow && (!byteOp || !ea[0]); // see RULE_03
        memWeLo = opNow && state_reg.wr && !abortNow && (!byteOp || ea[0]);
        rdByte = ea[0] ? memRdWord[7:0] : memRdWord[15:8];
    end

    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.rd = 16'h0000;
        events = '0;
        clearMask = '0;
        resetNow = 1'b0;

        // Register writes.
        if (regWr) begin
            case (regAddr)
                CFG_IDX: begin
                    state_next.stop = regWrData[STOP_BIT];
                    state_next.space = regWrData[SPACE_LSB+1:SPACE_LSB];
                    // Writing zero also stops the standby monitoring.
                    state_next.power_down_status_bit = regWrData[PDS_BIT]; // see RULE_11
                    if (!state_reg.lock) begin
                        state_next.lock = regWrData[LOCK_BIT]; // see RULE_06
                    end
                end
                BASE_HIGH_IDX: begin
                    if (baseOpen) begin
                        state_next.baseHigh = regWrData[7:0]; // see RULE_05
                    end else begin
                        events[EV_LOCKED_WRITE] = 1'b1;
                    end
                end
                BASE_LOW_IDX: begin
                    if (baseOpen) begin
                        state_next.baseLow = regWrData & LOW_MASK; // see RULE_05
                    end else begin
                        events[EV_LOCKED_WRITE] = 1'b1;
                    end
                end
                STATUS_IDX: begin
                    clearMask = regWrData[EV_COUNT-1:0];
                end
                TEST_IDX: begin // see RULE_04
                    // The test register is not implemented, so the write is dropped.
                end
                MASK_IDX: begin
                    state_next.mask = regWrData[EV_COUNT-1:0];
                end
                default: begin
                end
            endcase
        end

        // Loss of standby voltage clears a set flag, winning over a software write; a set from zero still takes.
        if (standbyVoltageLow && state_reg.power_down_status_bit) begin
            state_next.power_down_status_bit = 1'b0; // see RULE_10
            events[EV_POWER_LOSS] = 1'b1;
        end

        // Register reads; unimplemented bits and indices read zero.
        if (regRd) begin
            case (regAddr) // see RULE_04
                CFG_IDX: begin
                    state_next.rd[STOP_BIT] = state_reg.stop;
                    state_next.rd[LOCK_BIT] = state_reg.lock;
                    state_next.rd[SPACE_LSB+1:SPACE_LSB] = state_reg.space;
                    state_next.rd[PDS_BIT] = state_reg.power_down_status_bit;
                end
                BASE_HIGH_IDX: state_next.rd = {8'h00, state_reg.baseHigh};
                BASE_LOW_IDX: state_next.rd = state_reg.baseLow & LOW_MASK;
                STATUS_IDX: state_next.rd = {{(16 - EV_COUNT){1'b0}}, state_reg.status};
                TEST_IDX: state_next.rd = 16'h0000; // see RULE_04
                MASK_IDX: state_next.rd = {{(16 - EV_COUNT){1'b0}}, state_reg.mask};
                default: state_next.rd = 16'h0000;
            endcase
        end

        // Array access sequencer.
        case (state_reg.st)
            ST_IDLE: begin
                if (syncReset) begin
                    resetNow = 1'b1;
                end else if (takeOk) begin
                    if (onStandbySupply) begin
                        events[EV_STANDBY_REFUSE] = 1'b1; // see RULE_13
                    end else begin
                        state_next.st = ST_C1A;
                        state_next.addr = arrAddr;
                        state_next.size = arrSize;
                        state_next.wr = arrWrite;
                        state_next.wdata = arrWrData;
                        state_next.rdata = 32'h00000000;
                        state_next.pendRst = 1'b0;
                    end
                end
            end
            ST_C1A: begin
                state_next.st = ST_C1B;
                state_next.pendRst = state_reg.pendRst | syncReset;
            end
            ST_C1B: begin
                if (state_reg.size == SIZE_LONG) begin
                    state_next.rdata[31:16] = memRdWord;
                end else if (byteOp && twoPart) begin
                    state_next.rdata[15:8] = rdByte;
                end else if (byteOp) begin
                    state_next.rdata[7:0] = rdByte;
                end else begin
                    state_next.rdata[15:0] = memRdWord;
                end
                // Reset during the first word of a long word ends it here.
                if (twoPart && !((state_reg.size == SIZE_LONG) &&
                    (state_reg.pendRst || syncReset))) begin // see RULE_16
                    state_next.st = ST_C2A;
                end else begin
                    state_next.st = ST_IDLE;
                    state_next.ack = 1'b1;
                    resetNow = state_reg.pendRst | syncReset; // see RULE_15
                end
            end
            ST_C2A: begin
                state_next.st = ST_C2B;
                state_next.pendRst = state_reg.pendRst | syncReset;
            end
            ST_C2B: begin
                if (state_reg.size == SIZE_LONG) begin
                    state_next.rdata[15:0] = memRdWord;
                end else begin
                    state_next.rdata[7:0] = rdByte;
                end
                // The second word finishes before reset is taken, unless a switch to the standby supply drops it.
                state_next.st = ST_IDLE;
                state_next.ack = 1'b1;
                resetNow = state_reg.pendRst | syncReset; // see RULE_16
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase

        // The current bus cycle writes nothing and no ack follows, yet a pending reset is still taken.
        if (abortNow) begin
            state_next.st = ST_IDLE;
            state_next.ack = 1'b0;
            events[EV_STANDBY_REFUSE] = 1'b1; // see RULE_13
            resetNow = state_reg.pendRst | syncReset;
        end

        // The standby flag survives synchronous reset so the power history is kept.
        if (resetNow) begin
            state_next.stop = RST_STOP; // see RULE_14
            state_next.space = RST_SPACE;
            state_next.baseHigh = RST_BASE_HIGH;
            state_next.baseLow = RST_BASE_LOW;
            state_next.lock = RST_LOCK;
            state_next.pendRst = 1'b0;
        end

        // A new event wins over a clear in the same cycle.
        state_next.status = (state_reg.status & ~clearMask) | events;
        state_next.irq = |(state_next.status & state_next.mask);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_reg.st <= ST_IDLE;
            state_reg.addr <= 24'h000000;
            state_reg.size <= SIZE_BYTE;
            state_reg.wr <= 1'b0;
            state_reg.wdata <= 32'h00000000;
            state_reg.rdata <= 32'h00000000;
            state_reg.pendRst <= 1'b0;
            state_reg.stop <= RST_STOP; // see RULE_14
            state_reg.lock <= RST_LOCK;
            state_reg.space <= RST_SPACE;
            state_reg.power_down_status_bit <= RST_PDS;
            state_reg.baseHigh <= RST_BASE_HIGH;
            state_reg.baseLow <= RST_BASE_LOW;
            state_reg.status <= '0;
            state_reg.mask <= '0;
            state_reg.rd <= 16'h0000;
            state_reg.ack <= 1'b0;
            state_reg.irq <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // The array itself has no reset; its contents must outlive resets.
    always_ff @(posedge clock) begin
        if (memWeHi) begin
            mem[memIdx][15:8] <= memWdata[15:8];
        end
        if (memWeLo) begin
            mem[memIdx][7:0] <= memWdata[7:0];
        end
    end

    assign regRdData = state_reg.rd;
    assign arrRdData = state_reg.rdata;
    assign arrAck = state_reg.ack;
    assign irq = state_reg.irq;
endmodule
`default_nettype wire

// *** tb/srm_top_assertions.sv ***
// Port-level timing checks of the standby RAM module.
`timescale 1ns/100ps
`default_nettype none
module srm_top_assertions
    import srm_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic syncReset,
    input wire logic regRd,
    input wire logic [15:0] regRdData,
    input wire logic arrReq,
    input wire logic [23:0] arrAddr,
    input wire logic [1:0] arrSize,
    input wire logic [31:0] arrRdData,
    input wire logic arrAck,
    input wire logic onStandbySupply
);
    logic oddAddr;
    assign oddAddr = arrAddr[0];
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    AST_ACK_PULSE: assert property (arrAck |=> !arrAck)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (arrAck |-> $past(arrReq, 3) || $past(arrReq, 5))
        else $error("ack without request three or five cycles before");
    AST_TWO_PART: assert property (arrAck && $past(arrReq, 5) |->
        $past(arrSize, 5) == SIZE_LONG || ($past(arrSize, 5) == SIZE_WORD && $past(oddAddr, 5)))
        else $error("one-part access took two bus cycles");
    AST_LONG_NOT_EARLY: assert property (arrReq && arrSize == SIZE_LONG && !syncReset
        ##1 !syncReset [*2] |=> !arrAck)
        else $error("long access acknowledged after one bus cycle");
    AST_STANDBY: assert property (arrReq && onStandbySupply |-> ##3 !arrAck ##2 !arrAck)
        else $error("access answered on standby supply");
    AST_RESET_QUIET: assert property ($fell(reset) |-> !arrAck [*6])
        else $error("array answered while stopped after reset");
    AST_RD_ZERO: assert property (!regRd |=> regRdData == 16'h0000)
        else $error("register data outside read slot");
    AST_RD_HOLD: assert property (arrAck && !arrReq |=> $stable(arrRdData))
        else $error("array read data not held after ack");
    AST_STANDBY_SILENT: assert property (onStandbySupply |=> !arrAck)
        else $error("array answered while on standby supply");
endmodule
bind srm_top srm_top_assertions chk (
    .clock(clock), .reset(reset), .syncReset(syncReset), .regRd(regRd),
    .regRdData(regRdData), .arrReq(arrReq), .arrAddr(arrAddr), .arrSize(arrSize),
    .arrRdData(arrRdData), .arrAck(arrAck), .onStandbySupply(onStandbySupply)
);
`default_nettype wire

// *** tb/srm_cpu_model.sv ***
// Bus master model that drives the array port.
`timescale 1ns/100ps
`default_nettype none
module srm_cpu_model (
    input wire logic clock,
    output logic arrReq,
    output logic [23:0] arrAddr,
    output logic arrWrite,
    output logic [1:0] arrSize,
    output logic arrProgram,
    output logic arrSuper,
    output logic [31:0] arrWrData,
    input wire logic arrAck,
    input wire logic [31:0] arrRdData
);
    initial begin
        arrReq = 1'b0;
        arrAddr = 24'h000000;
        arrWrite = 1'b0;
        arrSize = 2'h0;
        arrProgram = 1'b0;
        arrSuper = 1'b0;
        arrWrData = 32'h00000000;
    end
    // Address and data are inverted after the take so nothing leans on stale values.
    task automatic access(input logic w, input logic [1:0] sz, input logic [23:0] a,
            input logic [31:0] d, input logic p, input logic s, output int lat,
            output logic [31:0] rd);
        lat = 0;
        rd = 32'h00000000;
        @(posedge clock);
        arrReq <= 1'b1;
        arrAddr <= a;
        arrWrite <= w;
        arrSize <= sz;
        arrProgram <= p;
        arrSuper <= s;
        arrWrData <= d;
        @(posedge clock);
        arrReq <= 1'b0;
        arrAddr <= ~a;
        arrWrData <= ~d;
        for (int i = 1; i <= 8 && lat == 0; i++) begin
            @(posedge clock);
            #1;
            if (arrAck === 1'b1) begin
                lat = i;
                rd = arrRdData;
            end
        end
    endtask
endmodule
`default_nettype wire

// *** tb/srm_top_test.sv ***
// Self-checking bench of the standby RAM module.
`timescale 1ns/100ps
`default_nettype none
module srm_top_test;
    import srm_pkg::*;
    logic clock, reset, syncReset, regWr, regRd, arrReq, arrWrite, arrProgram, arrSuper;
    logic arrAck, onStandbySupply, standbyVoltageLow, irq;
    logic [2:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic [23:0] arrAddr;
    logic [1:0] arrSize;
    logic [31:0] arrWrData, arrRdData;
    int error_cnt = 0;
    int checked = 0;
    srm_top #(.ARRAY_KB(2)) dut (.clock(clock), .reset(reset), .syncReset(syncReset),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .arrReq(arrReq), .arrAddr(arrAddr), .arrWrite(arrWrite),
        .arrSize(arrSize), .arrProgram(arrProgram), .arrSuper(arrSuper),
        .arrWrData(arrWrData), .arrRdData(arrRdData), .arrAck(arrAck),
        .onStandbySupply(onStandbySupply), .standbyVoltageLow(standbyVoltageLow), .irq(irq));
    srm_cpu_model cpu (.clock(clock), .arrReq(arrReq), .arrAddr(arrAddr),
        .arrWrite(arrWrite), .arrSize(arrSize), .arrProgram(arrProgram),
        .arrSuper(arrSuper), .arrWrData(arrWrData), .arrAck(arrAck), .arrRdData(arrRdData));
    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        @(posedge clock);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1;
        chk({16'h0000, regRdData}, {16'h0000, e});
    endtask
    // A refused access shows as latency zero, since the model gives up after eight cycles.
    task automatic acc(input logic w, input logic [1:0] sz, input logic [23:0] a,
            input logic [31:0] d, input logic p, input logic s, input int el,
            input logic [31:0] er);
        int lat;
        logic [31:0] rd;
        cpu.access(w, sz, a, d, p, s, lat, rd);
        chk(32'(lat), 32'(el));
        if (!w) chk(rd, er);
    endtask
    task automatic syncHit(input logic [1:0] sz, input logic [23:0] a, input logic [31:0] er,
            input int el, input int dly);
        fork
            acc(1'b0, sz, a, 32'h0, 1'b1, 1'b1, el, er);
            begin
                repeat (dly) @(posedge clock);
                syncReset <= 1'b1;
                @(posedge clock);
                syncReset <= 1'b0;
            end
        join
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (4000) @(posedge clock);
        $display("mismatch at %0t: watchdog expired", $time);
        error_cnt++;
        summarize();
    end
    initial begin
        reset = 1'b1;
        syncReset = 1'b0;
        regAddr = 3'h0;
        regWrData = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        onStandbySupply = 1'b0;
        standbyVoltageLow = 1'b0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rdc(CFG_IDX, 16'h8100);
        rdc(TEST_IDX, 16'h0000);
        rdc(3'h6, 16'h0000);
        acc(1'b0, SIZE_BYTE, 24'h000000, 32'h0, 1'b1, 1'b1, 0, 32'h0);
        wr(BASE_HIGH_IDX, 16'hFF00);
        rdc(BASE_HIGH_IDX, 16'h0000);
        wr(BASE_LOW_IDX, 16'h17FF);
        rdc(BASE_LOW_IDX, 16'h1000);
        wr(CFG_IDX, 16'h0000);
        wr(BASE_LOW_IDX, 16'h2000);
        rdc(BASE_LOW_IDX, 16'h1000);
        chk({31'h0, irq}, 32'h0);
        wr(MASK_IDX, 16'h0004);
        rdc(STATUS_IDX, 16'h0004);
        chk({31'h0, irq}, 32'h1);
        wr(STATUS_IDX, 16'h0004);
        rdc(STATUS_IDX, 16'h0000);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, SIZE_LONG, 24'h001000, 32'h11223344, 1'b0, 1'b1, 4, 32'h0);
        acc(1'b1, SIZE_WORD, 24'h001004, 32'h00005566, 1'b0, 1'b1, 2, 32'h0);
        acc(1'b1, SIZE_BYTE, 24'h001005, 32'h000000AB, 1'b0, 1'b1, 2, 32'h0);
        acc(1'b0, SIZE_WORD, 24'h001004, 32'h0, 1'b0, 1'b1, 2, 32'h000055AB);
        acc(1'b0, SIZE_WORD, 24'h001003, 32'h0, 1'b0, 1'b1, 4, 32'h00004455);
        acc(1'b0, SIZE_LONG, 24'h001000, 32'h0, 1'b0, 1'b1, 4, 32'h11223344);
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b0, 1'b1, 2, 32'h00000022);
        acc(1'b0, SIZE_BYTE, 24'h001800, 32'h0, 1'b1, 1'b1, 0, 32'h0);
        wr(CFG_IDX, 16'h0100);
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b0, 1'b1, 0, 32'h0);
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b1, 1'b1, 2, 32'h00000022);
        wr(CFG_IDX, 16'h0200);
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b0, 1'b0, 0, 32'h0);
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b0, 1'b1, 2, 32'h00000022);
        @(posedge clock);
        onStandbySupply <= 1'b1;
        acc(1'b0, SIZE_BYTE, 24'h001001, 32'h0, 1'b1, 1'b1, 0, 32'h0);
        @(posedge clock);
        onStandbySupply <= 1'b0;
        rdc(STATUS_IDX, 16'h0002);
        wr(CFG_IDX, 16'h0080);
        rdc(CFG_IDX, 16'h0080);
        @(posedge clock);
        standbyVoltageLow <= 1'b1;
        @(posedge clock);
        standbyVoltageLow <= 1'b0;
        rdc(CFG_IDX, 16'h0000);
        rdc(STATUS_IDX, 16'h0003);
        wr(CFG_IDX, 16'h0080);
        wr(CFG_IDX, 16'h0000);
        rdc(CFG_IDX, 16'h0000);
        syncHit(SIZE_LONG, 24'h001000, 32'h11220000, 2, 2);
        wr(BASE_LOW_IDX, 16'h1000);
        wr(CFG_IDX, 16'h0000);
        syncHit(SIZE_WORD, 24'h001004, 32'h000055AB, 2, 2);
        rdc(CFG_IDX, 16'h8100);
        wr(BASE_LOW_IDX, 16'h1000);
        wr(CFG_IDX, 16'h0000);
        syncHit(SIZE_LONG, 24'h001000, 32'h11223344, 4, 4);
        rdc(CFG_IDX, 16'h8100);
        wr(BASE_HIGH_IDX, 16'h0008);
        wr(BASE_LOW_IDX, 16'h0000);
        wr(CFG_IDX, 16'h0000);
        acc(1'b0, SIZE_BYTE, 24'h080000, 32'h0, 1'b1, 1'b1, 0, 32'h0);
        wr(CFG_IDX, 16'h8800);
        wr(CFG_IDX, 16'h8000);
        rdc(CFG_IDX, 16'h8800);
        wr(BASE_HIGH_IDX, 16'h0000);
        rdc(BASE_HIGH_IDX, 16'h0008);
        summarize();
    end
endmodule
`default_nettype wire
